// ---- hdl/exception_priority_vector_logic.sv ----
`timescale 1ns/1ps
`include "exc_consts.svh"

// How it works
// - the vector fetch address is the table base plus four times the exception number, word 0 being the stack value.
// - peripheral line n raises exception n plus 16, reserved lines never pend, and line 43 is the top source.
// - every programmable priority leaves reset at zero.
// - after reset every vector fetch uses base zero.
// - a base write inside the legal window is taken and steers all later fetches.
// - a smaller priority value is the more urgent one.
// - reset, hard fault and the non-maskable interrupt have fixed priorities; all others use their setting.
// - programmable priorities are three bits wide, values 0 to 7.
// - the negative fixed priorities beat every programmable one.
// - among equal priorities the smallest exception number wins.
// - a pending exception strictly more urgent than the running handler preempts it.
// - an equal-priority exception does not preempt and just stays pending.
// - faults and system exceptions other than reset and the debug monitor are classified and flagged with the selected exception.
// - fixed priorities are -3, -2 and -1, and the non-maskable interrupt cannot be disabled.
module exception_priority_vector_logic #(
    parameter int NUM_IRQ = 44
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // peripheral interrupt lines, one-cycle or level requests
    input  wire logic [NUM_IRQ-1:0]   irq_line,
    // system exception requests
    input  wire logic                 nmi_req,
    input  wire logic                 hard_fault_req,
    input  wire logic                 mem_fault_req,
    input  wire logic                 bus_fault_req,
    input  wire logic                 usage_fault_req,
    input  wire logic                 supervisor_call_exception,
    input  wire logic                 debug_mon_req,
    input  wire logic                 pendable_service_request,
    input  wire logic                 systick_req,
    // priority setting port
    input  wire logic                 prio_wr_en,
    input  wire exc_pkg::exc_num_t    prio_wr_num,
    input  wire exc_pkg::prio_field_t prio_wr_val,
    // vector table base write
    input  wire logic                 vector_base_offset_reg_wr,
    input  wire logic [31:0]          vector_base_offset_reg_data,
    // core handshake
    input  wire logic                 core_ack,
    input  wire logic                 core_return,
    // selection towards the core
    output logic                      take_req,
    output exc_pkg::exc_num_t         take_num,
    output logic [31:0]               vector_addr,
    output logic                      take_is_fault,
    output logic                      take_is_system,
    // state
    output logic [31:0]               vector_base,
    output exc_pkg::prio_t            run_prio,
    output logic                      handler_active
);

    localparam int NEXC = exc_pkg::NUM_EXC;

    // refuse line counts that the exception numbering cannot hold
    if (NUM_IRQ < 1 || NUM_IRQ > NEXC - 16) begin : g_bad_num_irq
        $error("NUM_IRQ out of range");
    end

    exc_pkg::prio_field_t prio_ff [NEXC];
    exc_pkg::prio_t       eff_prio [NEXC];
    logic [NEXC-1:0]      pend_ff;
    logic [NEXC-1:0]      act_ff;
    logic [NEXC-1:0]      req_vec;
    logic [NEXC-1:0]      impl_mask;
    logic [31:0]          vector_base_ff;
    logic                 take_req_ff;
    exc_pkg::exc_num_t    take_num_ff;
    logic [31:0]          vector_addr_ff;
    logic                 take_is_fault_ff;
    logic                 take_is_system_ff;
    exc_pkg::prio_t       run_prio_ff;
    logic                 handler_active_ff;
    logic                 best_found;
    exc_pkg::exc_num_t    best_num;
    logic                 run_found;
    exc_pkg::exc_num_t    run_num;
    logic                 nxt_take_req;

    // most urgent candidate: strict compare upward keeps the lowest number on ties
    function automatic exc_pkg::exc_num_t pick_best(
        input logic [NEXC-1:0] cand,
        input exc_pkg::prio_t  pr [NEXC]
    );
        exc_pkg::exc_num_t num;
        exc_pkg::prio_t    best;
        logic              seen;
        num  = 6'h00;
        best = 4'sh7;
        seen = 1'b0;
        for (int i = 0; i < NEXC; i++) begin
            if (cand[i] && (!seen || pr[i] < best)) begin
                num  = 6'(i);
                best = pr[i];
                seen = 1'b1;
            end
        end
        return num;
    endfunction : pick_best

    // table base as a write would set it, low byte held at zero
    function automatic logic [31:0] align_base(input logic [31:0] d);
        return {d[31:`VEC_ALIGN_BITS], 8'h00};
    endfunction : align_base

    // one bit of a class mask, picked by exception number
    function automatic logic in_mask(
        input logic [NEXC-1:0]  mask,
        input exc_pkg::exc_num_t n
    );
        return mask[n];
    endfunction : in_mask

    // lines beyond the configured count are not implemented
    always_comb begin
        impl_mask = `EXC_IMPL_MASK;
        for (int i = 16; i < NEXC; i++) begin
            if (i - 16 >= NUM_IRQ) begin
                impl_mask[i] = 1'b0;
            end
        end
    end

    // gather requests into exception-number order
    always_comb begin
        req_vec = '0;
        req_vec[`EXC_NUM_NMI]        = nmi_req;
        req_vec[`EXC_NUM_HARD_FAULT] = hard_fault_req;
        req_vec[`EXC_NUM_MEM_FAULT]  = mem_fault_req;
        req_vec[`EXC_NUM_BUS_FAULT]  = bus_fault_req;
        req_vec[`EXC_NUM_USE_FAULT]  = usage_fault_req;
        req_vec[`EXC_NUM_SVC]        = supervisor_call_exception;
        req_vec[`EXC_NUM_DEBUG_MON]  = debug_mon_req;
        req_vec[`EXC_NUM_PENDABLE_SERVICE_REQUEST]     = pendable_service_request;
        req_vec[`EXC_NUM_SYSTICK]    = systick_req;
        for (int n = 0; n < NUM_IRQ; n++) begin
            req_vec[n + 16] = irq_line[n];
        end
        req_vec = req_vec & impl_mask;
    end

    // effective priority of each exception number
    always_comb begin
        for (int i = 0; i < NEXC; i++) begin
            eff_prio[i] = $signed({1'b0, prio_ff[i]});
        end
        eff_prio[`EXC_NUM_RESET]      = `PRIO_RESET;
        eff_prio[`EXC_NUM_NMI]        = `PRIO_NMI;
        eff_prio[`EXC_NUM_HARD_FAULT] = `PRIO_HARD_FAULT;
    end

    // programmable priority store; writes to fixed or absent numbers are dropped
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < NEXC; i++) begin
                prio_ff[i] <= `PRIO_RESET_VALUE;
            end
        end else if (prio_wr_en && int'(prio_wr_num) < NEXC) begin
            if (impl_mask[prio_wr_num]
                && prio_wr_num != `EXC_NUM_RESET
                && prio_wr_num != `EXC_NUM_NMI
                && prio_wr_num != `EXC_NUM_HARD_FAULT) begin
                prio_ff[prio_wr_num] <= prio_wr_val;
            end
        end
    end

    // vector table base: zero after reset, relocated by in-window writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            vector_base_ff <= `VEC_BASE_RESET;
        end else if (vector_base_offset_reg_wr
                     && align_base(vector_base_offset_reg_data) >= `VEC_BASE_MIN
                     && align_base(vector_base_offset_reg_data) <= `VEC_BASE_MAX) begin
            vector_base_ff <= align_base(vector_base_offset_reg_data);
        end
    end

    // arbitration over pending and over active exceptions
    always_comb begin
        best_found   = |pend_ff;
        best_num     = pick_best(pend_ff, eff_prio);
        run_found    = |act_ff;
        run_num      = pick_best(act_ff, eff_prio);
        // preempt only on strictly more urgent, equal stays pending
        nxt_take_req = best_found && !core_ack
                       && (!run_found || eff_prio[best_num] < eff_prio[run_num]);
    end

    // pending flags: a new request wins over the clear by acknowledge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pend_ff                 <= '0;
            pend_ff[`EXC_NUM_RESET] <= 1'b1;
        end else begin
            for (int i = 0; i < NEXC; i++) begin
                if (req_vec[i]) begin
                    pend_ff[i] <= 1'b1;
                end else if (core_ack && take_req_ff && take_num_ff == 6'(i)) begin
                    pend_ff[i] <= 1'b0;
                end
            end
        end
    end

    // active flags: set on acknowledge, most urgent active cleared on return
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            act_ff <= '0;
        end else begin
            for (int i = 0; i < NEXC; i++) begin
                if (core_ack && take_req_ff && take_num_ff == 6'(i)) begin
                    act_ff[i] <= 1'b1;
                end else if (core_return && run_found && run_num == 6'(i)) begin
                    act_ff[i] <= 1'b0;
                end
            end
        end
    end

    // registered selection towards the core
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            take_req_ff       <= 1'b0;
            take_num_ff       <= 6'h00;
            vector_addr_ff    <= `VEC_BASE_RESET;
            take_is_fault_ff  <= 1'b0;
            take_is_system_ff <= 1'b0;
        end else begin
            take_req_ff       <= nxt_take_req;
            take_num_ff       <= best_num;
            vector_addr_ff    <= vector_base_ff + {24'h000000, best_num, 2'b00};
            take_is_fault_ff  <= best_found && in_mask(`EXC_FAULT_MASK, best_num);
            take_is_system_ff <= best_found && in_mask(`EXC_SYSTEM_MASK, best_num);
        end
    end

    // running priority; idle shows the weakest programmable level
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            run_prio_ff       <= 4'sh7;
            handler_active_ff <= 1'b0;
        end else begin
            run_prio_ff       <= run_found ? eff_prio[run_num] : 4'sh7;
            handler_active_ff <= run_found;
        end
    end

    assign take_req       = take_req_ff;
    assign take_num       = take_num_ff;
    assign vector_addr    = vector_addr_ff;
    assign take_is_fault  = take_is_fault_ff;
    assign take_is_system = take_is_system_ff;
    assign vector_base    = vector_base_ff;
    assign run_prio       = run_prio_ff;
    assign handler_active = handler_active_ff;

endmodule : exception_priority_vector_logic

// ---- hdl/exc_consts.svh ----
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH

// exception numbers of the system exceptions
`define EXC_NUM_RESET      6'h01
`define EXC_NUM_NMI        6'h02
`define EXC_NUM_HARD_FAULT 6'h03
`define EXC_NUM_MEM_FAULT  6'h04
`define EXC_NUM_BUS_FAULT  6'h05
`define EXC_NUM_USE_FAULT  6'h06
`define EXC_NUM_SVC        6'h0b
`define EXC_NUM_DEBUG_MON  6'h0c
`define EXC_NUM_PENDABLE_SERVICE_REQUEST     6'h0e
`define EXC_NUM_SYSTICK    6'h0f
// first exception number used by peripheral line 0
`define EXC_IRQ_BASE       6'h10

// fixed priorities, four-bit signed
`define PRIO_RESET         4'hd
`define PRIO_NMI           4'he
`define PRIO_HARD_FAULT    4'hf
// reset value of every programmable priority
`define PRIO_RESET_VALUE   3'h0

// implemented exception numbers 1..59, reserved lines left out
`define EXC_IMPL_MASK      60'h899_ffff_c1ff_d87e
// faults and system exceptions
`define EXC_FAULT_MASK     60'h000_0000_0000_0078
`define EXC_SYSTEM_MASK    60'h000_0000_0000_c87c

// vector table base after reset and the legal base window
`define VEC_BASE_RESET     32'h0000_0000
`define VEC_BASE_MIN       32'h0000_0100
`define VEC_BASE_MAX       32'h3fff_ff00
`define VEC_ALIGN_BITS     8

`endif

// ---- hdl/exc_pkg.sv ----
package exc_pkg;

    // exception number, 0..63
    typedef logic [5:0]        exc_num_t;
    // signed priority: fixed values negative, programmable 0..7
    typedef logic signed [3:0] prio_t;
    // programmable priority field
    typedef logic [2:0]        prio_field_t;

    localparam int NUM_EXC = 60;

endpackage : exc_pkg

// ---- tb/exception_priority_vector_logic_properties.sv ----
`timescale 1ns/1ps
module exception_priority_vector_logic_properties (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              reset,
    // inputs watched
    input wire logic              core_ack,
    input wire logic              vector_base_offset_reg_wr,
    input wire logic [31:0]       vector_base_offset_reg_data,
    // outputs watched
    input wire logic              take_req,
    input wire exc_pkg::exc_num_t take_num,
    input wire logic [31:0]       vector_addr,
    input wire logic              take_is_fault,
    input wire logic              take_is_system,
    input wire logic [31:0]       vector_base,
    input wire exc_pkg::prio_t    run_prio,
    input wire logic              handler_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // base as a write would leave it, low byte dropped
    logic [31:0] wr_base;
    assign wr_base = {vector_base_offset_reg_data[31:8], 8'h00};
    chk_addr_form: assert property (
        take_req && $stable(vector_base) |-> vector_addr == vector_base + {take_num, 2'b00})
        else $error("vector address not base plus four times number");
    chk_base_align: assert property (vector_base[7:0] == 8'h00)
        else $error("vector base not 256 byte aligned");
    chk_base_window: assert property (
        vector_base == 32'h0 || (vector_base >= 32'h100 && vector_base <= 32'h3fff_ff00))
        else $error("vector base outside legal window");
    chk_base_write: assert property (
        vector_base_offset_reg_wr && wr_base >= 32'h100 && wr_base <= 32'h3fff_ff00
        |=> vector_base == $past(wr_base)) else $error("legal base write not taken");
    chk_base_stay: assert property (!vector_base_offset_reg_wr |=> $stable(vector_base))
        else $error("vector base moved without a write");
    chk_fault_flag: assert property (
        take_req |-> take_is_fault == (take_num inside {[6'h03:6'h06]}))
        else $error("fault flag wrong");
    chk_sys_flag: assert property (
        take_req |-> take_is_system == (take_num inside {[6'h02:6'h06], 6'h0b, 6'h0e, 6'h0f}))
        else $error("system flag wrong");
    chk_idle_prio: assert property (!handler_active |-> run_prio == 4'sh7)
        else $error("running priority not lowest while idle");
    chk_ack_drop: assert property (core_ack && take_req |=> !take_req)
        else $error("offer stands after acknowledge");
    chk_reset_first: assert property (
        $fell(reset) |=> take_req && take_num == 6'h01 && vector_addr == 32'h4)
        else $error("reset vector not offered first");
endmodule : exception_priority_vector_logic_properties

// ---- tb/core_model.sv ----
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              reset,
    // offer from the block
    input wire logic              take_req,
    input wire exc_pkg::exc_num_t take_num,
    input wire logic [31:0]       vector_addr,
    // wait cycles before acknowledging
    input wire logic [1:0]        ack_delay,
    // acknowledge and what was taken
    output logic                  core_ack,
    output exc_pkg::exc_num_t     got_num,
    output logic [31:0]           got_addr,
    output int                    got_cnt
);
    logic [1:0]  wait_ff;
    // handler word made from the fetched vector address with bit zero forced set
    logic [31:0] got_word;
    // acknowledge a standing offer after ack_delay cycles, one pulse
    always_ff @(posedge clk_sys) begin
        if (reset || !take_req || core_ack) begin
            wait_ff  <= 2'h0;
            core_ack <= 1'b0;
        end else if (wait_ff == ack_delay) begin
            core_ack <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
    // record the vector fetched at each acknowledge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            got_cnt <= 0;
        end else if (core_ack && take_req) begin
            got_num  <= take_num;
            got_addr <= vector_addr;
            got_word <= {vector_addr[31:1], 1'b1};
            got_cnt  <= got_cnt + 1;
        end
    end
endmodule : core_model

// ---- tb/exception_priority_vector_logic_tb.sv ----
`timescale 1ns/1ps
module exception_priority_vector_logic_tb;
    logic                 clk_sys = 1'b0;
    logic                 reset = 1'b1;
    logic [43:0]          irq_line = '0;
    logic [8:0]           sreq = '0;
    logic                 prio_wr_en = 1'b0;
    exc_pkg::exc_num_t    prio_wr_num = '0;
    exc_pkg::prio_field_t prio_wr_val = '0;
    logic                 vector_base_offset_reg_wr = 1'b0;
    logic [31:0]          vector_base_offset_reg_data = '0;
    logic                 core_return = 1'b0;
    logic [1:0]           ack_delay = 2'h0;
    logic                 core_ack, take_req, take_is_fault, take_is_system, handler_active;
    exc_pkg::exc_num_t    take_num, got_num;
    exc_pkg::prio_t       run_prio;
    logic [31:0]          vector_addr, vector_base, got_addr, base = '0;
    int                   got_cnt, n_fail = 0, compares = 0;
    // clock
    always #20 clk_sys = ~clk_sys;
    exception_priority_vector_logic u_exception_priority_vector_logic (.clk_sys, .reset,
        .irq_line, .nmi_req(sreq[8]), .hard_fault_req(sreq[7]), .mem_fault_req(sreq[6]),
        .bus_fault_req(sreq[5]), .usage_fault_req(sreq[4]), .supervisor_call_exception(sreq[3]),
        .debug_mon_req(sreq[2]), .pendable_service_request(sreq[1]), .systick_req(sreq[0]),
        .prio_wr_en, .prio_wr_num, .prio_wr_val, .vector_base_offset_reg_wr,
        .vector_base_offset_reg_data, .core_ack, .core_return, .take_req, .take_num,
        .vector_addr, .take_is_fault, .take_is_system, .vector_base, .run_prio, .handler_active);
    core_model u_core_model (.clk_sys, .reset, .take_req, .take_num, .vector_addr, .ack_delay,
        .core_ack, .got_num, .got_addr, .got_cnt);
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one-cycle request pulse: {nmi,hard,mem,bus,usage,svc,dbg,pend,tick} and lines
    task automatic req(input logic [8:0] s, input logic [43:0] l);
        cyc(1);
        {sreq, irq_line} = {s, l};
        cyc(1);
        {sreq, irq_line} = '0;
    endtask : req
    task automatic ret();
        cyc(1);
        core_return = 1'b1;
        cyc(1);
        core_return = 1'b0;
    endtask : ret
    task automatic wr_prio(input logic [5:0] n, input logic [2:0] v);
        cyc(1);
        {prio_wr_en, prio_wr_num, prio_wr_val} = {1'b1, n, v};
        cyc(1);
        prio_wr_en = 1'b0;
    endtask : wr_prio
    task automatic wr_base(input logic [31:0] d, input logic [31:0] exp);
        cyc(1);
        {vector_base_offset_reg_wr, vector_base_offset_reg_data} = {1'b1, d};
        cyc(1);
        vector_base_offset_reg_wr = 1'b0;
        base = exp;
        chk("vector base", vector_base, exp);
    endtask : wr_base
    // wait for the core to take an exception, then judge number and address
    task automatic take(input logic [5:0] n);
        int c0;
        c0 = got_cnt;
        for (int i = 0; i < 20 && got_cnt == c0; i++) cyc(1);
        chk("take count", got_cnt, c0 + 1);
        chk("taken number", {26'h0, got_num}, {26'h0, n});
        chk("vector address", got_addr, base + {24'h0, n, 2'b00});
    endtask : take
    task automatic st(input logic a, input logic [3:0] p);
        cyc(2);
        chk("handler active", {31'h0, handler_active}, {31'h0, a});
        chk("running priority", {28'h0, run_prio}, {28'h0, p});
    endtask : st
    task automatic t_reset();
        chk("vector base", vector_base, 32'h0);
        take(6'h01);
        st(1'b1, 4'hd);
        ret();
        st(1'b0, 4'h7);
    endtask : t_reset
    task automatic t_ties();
        req(9'h001, 44'h3);
        take(6'h0f);
        st(1'b1, 4'h0);
        chk("take request", {31'h0, take_req}, 32'h0);
        ret();
        take(6'h10);
        ret();
        take(6'h11);
        ret();
    endtask : t_ties
    task automatic t_sys();
        logic [5:0] order [6] = '{6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0e};
        ack_delay = 2'h2;
        req(9'h07e, '0);
        foreach (order[i]) begin
            take(order[i]);
            ret();
        end
        ack_delay = 2'h0;
    endtask : t_sys
    task automatic t_prio();
        wr_prio(6'h10, 3'h7);
        wr_prio(6'h11, 3'h2);
        wr_prio(6'h0f, 3'h1);
        wr_prio(6'h03, 3'h7);
        req(9'h000, 44'h3);
        take(6'h11);
        st(1'b1, 4'h2);
        req(9'h001, '0);
        take(6'h0f);
        st(1'b1, 4'h1);
        req(9'h080, '0);
        take(6'h03);
        st(1'b1, 4'hf);
        req(9'h100, '0);
        take(6'h02);
        st(1'b1, 4'he);
        repeat (4) ret();
        take(6'h10);
        ret();
        st(1'b0, 4'h7);
    endtask : t_prio
    task automatic t_lines();
        req(9'h000, 44'h100_0000_0200);
        cyc(5);
        chk("take request", {31'h0, take_req}, 32'h0);
        req(9'h000, 44'h800_0000_0000);
        take(6'h3b);
        ret();
    endtask : t_lines
    task automatic t_base();
        wr_base(32'h2000_0100, 32'h2000_0100);
        wr_base(32'h4000_0000, 32'h2000_0100);
        wr_base(32'h3fff_ff00, 32'h3fff_ff00);
        req(9'h000, 44'h800_0000_0000);
        take(6'h3b);
        ret();
    endtask : t_base
    // reset in mid-run: base back to zero, priorities back to zero
    task automatic t_again();
        cyc(1);
        reset = 1'b1;
        cyc(4);
        reset = 1'b0;
        base = '0;
        chk("vector base", vector_base, 32'h0);
        take(6'h01);
        ret();
        req(9'h000, 44'h3);
        take(6'h10);
        ret();
        take(6'h11);
        ret();
    endtask : t_again
    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) reset = 1'b0;
        t_reset();
        t_ties();
        t_sys();
        t_prio();
        t_lines();
        t_base();
        t_again();
        results();
    end
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #80000;
        n_fail++;
        results();
    end
endmodule : exception_priority_vector_logic_tb
bind exception_priority_vector_logic exception_priority_vector_logic_properties u_chk (
    .clk_sys, .reset, .core_ack, .vector_base_offset_reg_wr, .vector_base_offset_reg_data,
    .take_req, .take_num, .vector_addr, .take_is_fault, .take_is_system, .vector_base,
    .run_prio, .handler_active);
